// ---- include/dpsem_pkg.sv ----
// holds constants and carrier types for the semaphore host controller
// assumes one 125 MHz clock and a dual-port ram with semaphore space outside
package dpsem_pkg;

  // ********************************************************
  // widths and counts
  // ********************************************************
  localparam int unsigned FLAG_COUNT   = 8;
  localparam int unsigned INDEX_W      = 3;
  localparam int unsigned ADDR_W       = 15;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned CLK_PERIOD_NS = 8;

  // ********************************************************
  // timing: strobe and gap widths on the pins
  // ********************************************************
  localparam int unsigned STROBE_NS     = 24;
  localparam int unsigned STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_NS        = 16;
  localparam int unsigned GAP_CYC       = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 4;

  // ********************************************************
  // values written on data bit 0
  // ********************************************************
  localparam logic FLAG_TAKE    = 1'b0;
  localparam logic FLAG_RELEASE = 1'b1;

  // ********************************************************
  // commands from the user side
  // ********************************************************
  typedef enum logic [1:0] {
    DPSEM_CMD_ACQUIRE = 2'h0,
    DPSEM_CMD_RELEASE = 2'h1,
    DPSEM_CMD_PEEK    = 2'h2,
    DPSEM_CMD_INIT    = 2'h3
  } dpsem_cmd_t;

  typedef struct packed {
    dpsem_cmd_t         cmd;
    logic [INDEX_W-1:0] index;
  } dpsem_req_t;

  typedef struct packed {
    logic               granted;
    logic               flag;
    logic [INDEX_W-1:0] index;
  } dpsem_rsp_t;

  // pins driven toward the device port
  typedef struct packed {
    logic              chip_enable_n;
    logic              semaphore_select_n;
    logic              output_enable_n;
    logic              write_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_out;
    logic              data_oe_n;
  } dpsem_pins_t;

endpackage : dpsem_pkg

// ---- verilog/dpsem_strobe_timer.sv ----
// holds the strobe width timer used by the host sequencer
// assumes a single clock domain and a start pulse from the sequencer
`timescale 1ns/10ps

module dpsem_strobe_timer #(
  parameter int unsigned CNT_W = 4
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // control
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load,
  // status
  output logic                  done
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             done_ff;
  logic             nxt_done;

  // ********************************************************
  // count down from load, pulse done at the end
  // ********************************************************
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    if (start) begin
      nxt_cnt = load;
    end else if (cnt_ff != '0) begin
      nxt_cnt  = cnt_ff - 1'b1;
      nxt_done = (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

  // register counter state
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;

endmodule : dpsem_strobe_timer

// ---- verilog/dpsem_host.sv ----
// holds the host controller that drives one port of the semaphore space
// assumes the device port pins are wired straight to this block's pin group
// Overview of operation
// - flags active low: write zero requests, write one from same port releases
// - polling must drop select or oe between reads
// - acquire writes zero first, then reads back; zero means success
// - after a failed request keep reading or write one to withdraw
// - no power-up init; software writes one to all eight flags
// - chip enable held high while semaphore select is low
`timescale 1ns/10ps

module dpsem_host #(
  parameter int unsigned STROBE_CYC = dpsem_pkg::STROBE_CYC,
  parameter int unsigned GAP_CYC    = dpsem_pkg::GAP_CYC
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  // user request
  input  wire logic                  req_valid,
  input  wire dpsem_pkg::dpsem_req_t req,
  output logic                       req_ready,
  // user response
  output logic                       rsp_valid,
  output dpsem_pkg::dpsem_rsp_t      rsp,
  // device port pins
  output dpsem_pkg::dpsem_pins_t     pins,
  input  wire logic [dpsem_pkg::DATA_W-1:0] data_in
);

  // ********************************************************
  // sequencer states
  // ********************************************************
  typedef enum logic [5:0] {
    DPSEM_ST_IDLE  = 6'b00_0001,
    DPSEM_ST_WRITE = 6'b00_0010,
    DPSEM_ST_GAP   = 6'b00_0100,
    DPSEM_ST_READ  = 6'b00_1000,
    DPSEM_ST_DONE  = 6'b01_0000,
    DPSEM_ST_REST  = 6'b10_0000
  } dpsem_state_t;

  // builds the pin group for a semaphore cycle
  function automatic dpsem_pkg::dpsem_pins_t sem_pins(
    input logic                          active,
    input logic                          wr,
    input logic [dpsem_pkg::INDEX_W-1:0] idx,
    input logic                          bit0
  );
    dpsem_pkg::dpsem_pins_t p;
    p                    = '0;
    p.chip_enable_n      = 1'b1;
    p.semaphore_select_n = ~active;
    p.output_enable_n    = ~(active & ~wr);
    p.write_n            = ~(active & wr);
    p.addr               = {{(dpsem_pkg::ADDR_W-dpsem_pkg::INDEX_W){1'b0}}, idx};
    p.data_out           = {{(dpsem_pkg::DATA_W-1){1'b0}}, bit0};
    p.data_oe_n          = ~(active & wr);
    return p;
  endfunction : sem_pins

  dpsem_state_t                      state_ff, nxt_state;
  dpsem_pkg::dpsem_cmd_t             cmd_ff, nxt_cmd;
  logic [dpsem_pkg::INDEX_W-1:0]     idx_ff, nxt_idx;
  logic                              ready_ff, nxt_ready;
  logic                              rvalid_ff, nxt_rvalid;
  dpsem_pkg::dpsem_rsp_t             rsp_ff, nxt_rsp;
  dpsem_pkg::dpsem_pins_t            pins_ff, nxt_pins;
  logic                              tmr_start;
  logic [dpsem_pkg::CNT_W-1:0]       tmr_load;
  logic                              tmr_done;
  logic [dpsem_pkg::DATA_W-1:0]      din_meta_ff, din_sync_ff;
  logic                              flag_seen;

  // ********************************************************
  // input synchroniser for the data pins
  // ********************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      din_meta_ff <= '0;
      din_sync_ff <= '0;
    end else begin
      din_meta_ff <= data_in;
      din_sync_ff <= din_meta_ff;
    end
  end

  // flag spread over all bits; bit 0 suffices
  assign flag_seen = din_sync_ff[0];

  // strobe and gap timing
  dpsem_strobe_timer #(
    .CNT_W (dpsem_pkg::CNT_W)
  ) u_timer (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .start   (tmr_start),
    .load    (tmr_load),
    .done    (tmr_done)
  );

  // ********************************************************
  // sequencer next state
  // ********************************************************
  always_comb begin
    nxt_state  = state_ff;
    nxt_cmd    = cmd_ff;
    nxt_idx    = idx_ff;
    nxt_ready  = ready_ff;
    nxt_rvalid = 1'b0;
    nxt_rsp    = rsp_ff;
    nxt_pins   = pins_ff;
    tmr_start  = 1'b0;
    tmr_load   = dpsem_pkg::CNT_W'(STROBE_CYC);
    case (state_ff)
      DPSEM_ST_IDLE: begin
        nxt_pins = sem_pins(1'b0, 1'b0, '0, dpsem_pkg::FLAG_RELEASE);
        if (req_valid && ready_ff) begin
          nxt_ready = 1'b0;
          nxt_cmd   = req.cmd;
          nxt_idx   = (req.cmd == dpsem_pkg::DPSEM_CMD_INIT) ? '0 : req.index;
          tmr_start = 1'b1;
          if (req.cmd == dpsem_pkg::DPSEM_CMD_PEEK) begin
            nxt_state = DPSEM_ST_READ;
            nxt_pins  = sem_pins(1'b1, 1'b0, req.index, dpsem_pkg::FLAG_RELEASE);
          end else begin
            // write first, acquire then reads; zero takes, one frees
            nxt_state = DPSEM_ST_WRITE;
            nxt_pins  = sem_pins(1'b1, 1'b1,
                                 (req.cmd == dpsem_pkg::DPSEM_CMD_INIT) ? '0 : req.index,
                                 (req.cmd == dpsem_pkg::DPSEM_CMD_ACQUIRE) ?
                                   dpsem_pkg::FLAG_TAKE : dpsem_pkg::FLAG_RELEASE);
          end
        end
      end
      DPSEM_ST_WRITE: begin
        if (tmr_done) begin
          nxt_pins  = sem_pins(1'b0, 1'b0, idx_ff, dpsem_pkg::FLAG_RELEASE);
          tmr_start = 1'b1;
          tmr_load  = dpsem_pkg::CNT_W'(GAP_CYC);
          nxt_state = DPSEM_ST_GAP;
        end
      end
      DPSEM_ST_GAP: begin
        if (tmr_done) begin
          if (cmd_ff == dpsem_pkg::DPSEM_CMD_INIT &&
              idx_ff != dpsem_pkg::INDEX_W'(dpsem_pkg::FLAG_COUNT - 1)) begin
            // walk all eight flags with a one
            nxt_idx   = idx_ff + 1'b1;
            nxt_pins  = sem_pins(1'b1, 1'b1, idx_ff + 1'b1, dpsem_pkg::FLAG_RELEASE);
            tmr_start = 1'b1;
            nxt_state = DPSEM_ST_WRITE;
          end else if (cmd_ff == dpsem_pkg::DPSEM_CMD_ACQUIRE) begin
            nxt_pins  = sem_pins(1'b1, 1'b0, idx_ff, dpsem_pkg::FLAG_RELEASE);
            tmr_start = 1'b1;
            nxt_state = DPSEM_ST_READ;
          end else begin
            nxt_state = DPSEM_ST_DONE;
          end
        end
      end
      DPSEM_ST_READ: begin
        // sample late in strobe, after latch and sync delay
        if (tmr_done) begin
          nxt_rsp.flag = flag_seen;
          // zero back means this port owns it
          nxt_rsp.granted = (flag_seen == dpsem_pkg::FLAG_TAKE);
          // drop select and oe between reads
          nxt_pins  = sem_pins(1'b0, 1'b0, idx_ff, dpsem_pkg::FLAG_RELEASE);
          tmr_start = 1'b1;
          tmr_load  = dpsem_pkg::CNT_W'(GAP_CYC);
          nxt_state = DPSEM_ST_REST;
        end
      end
      DPSEM_ST_REST: begin
        if (tmr_done) begin
          nxt_state = DPSEM_ST_DONE;
        end
      end
      DPSEM_ST_DONE: begin
        // failed acquire left pending; user retries or releases
        nxt_rsp.index = idx_ff;
        if (cmd_ff != dpsem_pkg::DPSEM_CMD_ACQUIRE && cmd_ff != dpsem_pkg::DPSEM_CMD_PEEK) begin
          nxt_rsp.flag    = 1'b1;
          nxt_rsp.granted = 1'b0;
        end
        nxt_rvalid = 1'b1;
        nxt_ready  = 1'b1;
        nxt_state  = DPSEM_ST_IDLE;
      end
      default: begin
        nxt_state = DPSEM_ST_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
  end

  // ********************************************************
  // sequencer registers
  // ********************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff  <= DPSEM_ST_IDLE;
      cmd_ff    <= dpsem_pkg::DPSEM_CMD_PEEK;
      idx_ff    <= '0;
      ready_ff  <= 1'b1;
      rvalid_ff <= 1'b0;
      rsp_ff    <= '0;
      pins_ff   <= '{chip_enable_n: 1'b1, semaphore_select_n: 1'b1, output_enable_n: 1'b1,
                     write_n: 1'b1, addr: '0, data_out: '0, data_oe_n: 1'b1};
    end else begin
      state_ff  <= nxt_state;
      cmd_ff    <= nxt_cmd;
      idx_ff    <= nxt_idx;
      ready_ff  <= nxt_ready;
      rvalid_ff <= nxt_rvalid;
      rsp_ff    <= nxt_rsp;
      pins_ff   <= nxt_pins;
    end
  end

  assign req_ready = ready_ff;
  assign rsp_valid = rvalid_ff;
  assign rsp       = rsp_ff;
  assign pins      = pins_ff;

endmodule : dpsem_host

// ---- verification/dpsem_dev_model.sv ----
// device model: eight semaphore flags seen from two ports
// assumes left port pins come from the host, right port from the bench
`timescale 1ns/10ps

module dpsem_dev_model (
  // left port
  input  wire dpsem_pkg::dpsem_pins_t        pins,
  output logic [dpsem_pkg::DATA_W-1:0]       data_in,
  // right port
  input  wire logic                          r_wr,
  input  wire logic                          r_rd,
  input  wire logic [2:0]                    r_idx,
  input  wire logic                          r_bit,
  output logic                               r_q
);
  // ****
  // flag storage
  // ****
  // request latches get no init; ownership starts free
  logic [7:0] lreq_ff;
  logic [7:0] rreq_ff;
  logic [1:0] own_ff [8];
  logic       l_q;
  logic       l_wr;
  logic       l_rd;

  initial begin
    data_in = 8'h00;
    l_q = 1'b1;
    r_q = 1'b1;
    for (int i = 0; i < 8; i++) own_ff[i] = 2'd0;
  end

  assign l_wr = pins.chip_enable_n && !pins.semaphore_select_n && !pins.write_n;
  assign l_rd = pins.chip_enable_n && !pins.semaphore_select_n && !pins.output_enable_n;

  task automatic settle(int i);
    logic l0;
    logic r0;
    l0 = lreq_ff[i] === 1'b0;
    r0 = rreq_ff[i] === 1'b0;
    if (own_ff[i] == 2'd1 && lreq_ff[i] === 1'b1) own_ff[i] = r0 ? 2'd2 : 2'd0;
    else if (own_ff[i] == 2'd2 && rreq_ff[i] === 1'b1) own_ff[i] = l0 ? 2'd1 : 2'd0;
    else if (own_ff[i] == 2'd0) own_ff[i] = l0 ? 2'd1 : r0 ? 2'd2 : 2'd0;
  endtask : settle

  // ****
  // port writes
  // ****
  // first write wins
  always @(posedge l_wr) begin
    lreq_ff[pins.addr[2:0]] = pins.data_out[0];
    settle(pins.addr[2:0]);
  end
  always @(posedge r_wr) begin
    rreq_ff[r_idx] = r_bit;
    settle(r_idx);
  end

  always @(posedge l_rd) l_q = own_ff[pins.addr[2:0]] != 2'd1;
  always @(posedge r_rd) r_q = own_ff[r_idx] != 2'd2;
  // released bus shows the inverse of its last value
  always @(l_rd or l_q) data_in = l_rd ? {8{l_q}} : ~data_in;
endmodule : dpsem_dev_model

// ---- verification/dpsem_host_props.sv ----
// checker for the host pins and responses
// assumes binding onto dpsem_host, one clock domain
`timescale 1ns/10ps

module dpsem_host_props (
  // clock and reset
  input wire logic                          ref_clk,
  input wire logic                          nrst,
  // user side
  input wire logic                          req_valid,
  input wire dpsem_pkg::dpsem_req_t         req,
  input wire logic                          req_ready,
  input wire logic                          rsp_valid,
  input wire dpsem_pkg::dpsem_rsp_t         rsp,
  // device pins
  input wire dpsem_pkg::dpsem_pins_t        pins,
  input wire logic [dpsem_pkg::DATA_W-1:0]  data_in
);
  // ****
  // request in flight
  // ****
  logic                  take;
  dpsem_pkg::dpsem_req_t cur_ff;
  assign take = req_valid && req_ready;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) cur_ff <= '0;
    else if (take) cur_ff <= req;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ****
  // properties
  // ****
  // acquire answer: write, gap, read, rest and done end sixteen edges after take
  localparam int ACQ_RSP_MIN = 14;
  localparam int ACQ_RSP_MAX = 18;
  logic acq_take;
  logic peek_take;
  logic sem_on;
  assign acq_take  = take && req.cmd == dpsem_pkg::DPSEM_CMD_ACQUIRE;
  assign peek_take = take && req.cmd == dpsem_pkg::DPSEM_CMD_PEEK;
  assign sem_on    = !pins.semaphore_select_n;

  property p_ce_off;
    pins.chip_enable_n;
  endproperty
  a_ce_off: assert property (p_ce_off) else $error("chip enable low");
  property p_hi_addr;
    sem_on |-> pins.addr[dpsem_pkg::ADDR_W-1:dpsem_pkg::INDEX_W] == '0;
  endproperty
  a_hi_addr: assert property (p_hi_addr) else $error("upper address set");
  property p_idx;
    sem_on && cur_ff.cmd != dpsem_pkg::DPSEM_CMD_INIT |-> pins.addr[2:0] == cur_ff.index;
  endproperty
  a_idx: assert property (p_idx) else $error("wrong flag index");
  property p_wr_ctl;
    !pins.write_n |-> sem_on && pins.output_enable_n && !pins.data_oe_n;
  endproperty
  a_wr_ctl: assert property (p_wr_ctl) else $error("bad write strobes");
  property p_rel_one;
    !pins.write_n && cur_ff.cmd != dpsem_pkg::DPSEM_CMD_ACQUIRE |->
      pins.data_out[0] == dpsem_pkg::FLAG_RELEASE;
  endproperty
  a_rel_one: assert property (p_rel_one) else $error("release not one");
  property p_acq_zero;
    !pins.write_n && cur_ff.cmd == dpsem_pkg::DPSEM_CMD_ACQUIRE |->
      pins.data_out[0] == dpsem_pkg::FLAG_TAKE;
  endproperty
  a_acq_zero: assert property (p_acq_zero) else $error("request not zero");
  property p_acq_first;
    acq_take |=> pins.output_enable_n [*4];
  endproperty
  a_acq_first: assert property (p_acq_first) else $error("read before write");
  property p_acq_rsp;
    acq_take |-> ##[ACQ_RSP_MIN:ACQ_RSP_MAX] rsp_valid;
  endproperty
  a_acq_rsp: assert property (p_acq_rsp) else $error("acquire answer late");
  property p_peek;
    peek_take |=> pins.write_n [*8];
  endproperty
  a_peek: assert property (p_peek) else $error("peek wrote");
  property p_grant;
    rsp_valid && cur_ff.cmd == dpsem_pkg::DPSEM_CMD_ACQUIRE |->
      rsp.granted != rsp.flag && rsp.index == cur_ff.index;
  endproperty
  a_grant: assert property (p_grant) else $error("grant not flag low");
  property p_busy;
    take |=> !req_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  // every read strobe is dropped again so a poll sees a fresh value
  property p_rd_end;
    !pins.output_enable_n |-> ##[1:5] pins.output_enable_n;
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("read strobe stuck");

  c_won: cover property (rsp_valid && rsp.granted && cur_ff.cmd == dpsem_pkg::DPSEM_CMD_ACQUIRE);
  c_lost: cover property (rsp_valid && !rsp.granted && cur_ff.cmd == dpsem_pkg::DPSEM_CMD_ACQUIRE);
  c_init: cover property (rsp_valid && cur_ff.cmd == dpsem_pkg::DPSEM_CMD_INIT);
endmodule : dpsem_host_props

bind dpsem_host dpsem_host_props u_dpsem_host_props (.ref_clk(ref_clk), .nrst(nrst),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp(rsp), .pins(pins), .data_in(data_in));

// ---- verification/dpsem_host_test.sv ----
// self-checking bench for the semaphore host controller
// assumes the device model answers; its right port is driven here
`timescale 1ns/10ps

module dpsem_host_test;
  // ****
  // signals, design and model
  // ****
  localparam dpsem_pkg::dpsem_cmd_t ACQ = dpsem_pkg::DPSEM_CMD_ACQUIRE;
  localparam dpsem_pkg::dpsem_cmd_t REL = dpsem_pkg::DPSEM_CMD_RELEASE;
  localparam dpsem_pkg::dpsem_cmd_t PEK = dpsem_pkg::DPSEM_CMD_PEEK;
  logic                   ref_clk = 0;
  logic                   nrst = 0;
  logic                   req_valid = 0;
  dpsem_pkg::dpsem_req_t  req = '0;
  logic                   req_ready;
  logic                   rsp_valid;
  dpsem_pkg::dpsem_rsp_t  rsp;
  dpsem_pkg::dpsem_pins_t pins;
  logic [7:0]             data_in;
  logic                   r_wr = 0;
  logic                   r_rd = 0;
  logic                   r_bit = 0;
  logic                   r_q;
  logic [2:0]             r_idx = 0;
  logic [31:0]            seed = 32'h0000_c7cd;
  int                     n_fail = 0;
  int                     check_count = 0;
  int                     cyc = 0;
  dpsem_pkg::dpsem_rsp_t  exp_q[$];
  dpsem_pkg::dpsem_rsp_t  msk_q[$];

  always #4 ref_clk = ~ref_clk;

  dpsem_host u_dpsem_host (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .data_in(data_in));
  dpsem_dev_model u_dpsem_dev_model (.pins(pins), .data_in(data_in), .r_wr(r_wr), .r_rd(r_rd),
    .r_idx(r_idx), .r_bit(r_bit), .r_q(r_q));

  // ****
  // helpers
  // ****
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic chk(logic ok, string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : chk

  task automatic wait_rdy();
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= 200) chk(1'b0, "ready never returned");
  endtask : wait_rdy

  // one host request; the expected answer is queued first
  task automatic op(dpsem_pkg::dpsem_cmd_t c, logic [2:0] i, logic g, logic f, logic [4:0] m);
    wait_rdy();
    exp_q.push_back({g, f, i});
    msk_q.push_back(m);
    req.cmd = c;
    req.index = i;
    req_valid = 1;
    @(posedge ref_clk);
    #1 req_valid = 0;
    wait_rdy();
  endtask : op

  task automatic rw(logic [2:0] i, logic b);
    r_idx = i;
    r_bit = b;
    r_wr = 1;
    @(posedge ref_clk);
    #1 r_wr = 0;
    // let an edge pass so a following write shows a clean low first
    @(posedge ref_clk);
    #1;
  endtask : rw

  task automatic rr(logic [2:0] i, logic e, string msg);
    r_idx = i;
    r_rd = 1;
    @(posedge ref_clk);
    #1 chk(r_q === e, msg);
    r_rd = 0;
    // let an edge pass so a following read opens a fresh latch
    @(posedge ref_clk);
    #1;
  endtask : rr

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  // ****
  // response monitor and timeout
  // ****
  // looks mid-cycle, away from the edge that launches the response
  always @(negedge ref_clk) begin
    cyc++;
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected response");
      else begin
        chk(((rsp ^ exp_q[0]) & msk_q[0]) === 5'h00, "response differs");
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
    if (cyc == 20000) begin
      n_fail++;
      $display("MISMATCH t=%0t timeout", $time);
      stop_test();
    end
  end

  // ****
  // scenarios
  // ****
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 nrst = 1;
    op(dpsem_pkg::DPSEM_CMD_INIT, 3'h0, 1'b0, 1'b1, 5'h18);
    for (int i = 0; i < 8; i++) rw(i[2:0], 1'b1);
    $display("init done");
    op(ACQ, 3'h3, 1'b1, 1'b0, 5'h1f);
    rr(3'h3, 1'b1, "far side not one");
    rw(3'h3, 1'b0);
    rr(3'h3, 1'b1, "far request took flag");
    op(PEK, 3'h3, 1'b1, 1'b0, 5'h1f);
    op(REL, 3'h3, 1'b0, 1'b1, 5'h1f);
    rr(3'h3, 1'b0, "no handover");
    op(PEK, 3'h3, 1'b0, 1'b1, 5'h1f);
    $display("handover done");
    op(ACQ, 3'h3, 1'b0, 1'b1, 5'h1f);
    op(REL, 3'h3, 1'b0, 1'b1, 5'h1f);
    rw(3'h3, 1'b1);
    op(PEK, 3'h3, 1'b0, 1'b1, 5'h1f);
    rr(3'h3, 1'b1, "flag not free");
    $display("withdraw done");
    repeat (8) begin
      seed = xs(seed);
      op(ACQ, seed[2:0], 1'b1, 1'b0, 5'h1f);
      rr(seed[2:0], 1'b1, "random flag not held");
      op(REL, seed[2:0], 1'b0, 1'b1, 5'h1f);
    end
    $display("random flags done");
    for (int d = 0; d < 2; d++) begin
      fork
        op(ACQ, 3'h5, d[0], ~d[0], 5'h1f);
        begin
          // far side first in pass 0, six cycles after the host in pass 1
          if (d != 0) begin
            repeat (6) @(posedge ref_clk);
            #1;
          end
          rw(3'h5, 1'b0);
        end
      join
      rr(3'h5, d[0], "earlier request lost");
      op(REL, 3'h5, 1'b0, 1'b1, 5'h1f);
      rw(3'h5, 1'b1);
    end
    $display("contention done");
    chk(exp_q.size() == 0, "responses missing");
    stop_test();
  end
endmodule : dpsem_host_test
